/* File: design/mcsm_pkg.sv */
package mcsm_pkg;

	localparam int MCSM_AW = 4;
	localparam int MCSM_DW = 16;

	// Register offsets (word index on the plain register port)
	localparam logic [3:0] MCSM_OFF_CMD_CODE   = 4'h8;
	localparam logic [3:0] MCSM_OFF_CMD_STAT   = 4'h9;
	localparam logic [3:0] MCSM_OFF_SUB_CODE   = 4'ha;
	localparam logic [3:0] MCSM_OFF_SUB_STAT   = 4'hb;
	localparam logic [3:0] MCSM_OFF_CMD_REQ    = 4'h0;
	localparam logic [3:0] MCSM_OFF_SUB_REQ    = 4'h1;
	localparam logic [3:0] MCSM_OFF_IRQ_STAT   = 4'h2;
	localparam logic [3:0] MCSM_OFF_IRQ_MASK   = 4'h3;
	localparam logic [3:0] MCSM_OFF_CTRL       = 4'h4;

	// Status bit positions
	localparam int MCSM_BIT_BUSY  = 0;
	localparam int MCSM_BIT_HOLD  = 1;
	localparam int MCSM_BIT_FAIL  = 3;
	localparam int MCSM_BIT_ABS   = 7;
	localparam int MCSM_BIT_DONE  = 8;

	// Control register bits: each a one-cycle request when written 1
	localparam int MCSM_CTL_HOLD    = 0;
	localparam int MCSM_CTL_ABORT   = 1;
	localparam int MCSM_CTL_SUBABRT = 2;
	localparam int MCSM_CTL_SVON    = 3;
	localparam int MCSM_CTL_SVOFF   = 4;
	localparam int MCSM_CTL_ALMCLR  = 5;

	// Interrupt event bits
	localparam int MCSM_IRQ_CMD_DONE = 0;
	localparam int MCSM_IRQ_CMD_FAIL = 1;
	localparam int MCSM_IRQ_SUB_DONE = 2;
	localparam int MCSM_IRQ_SUB_FAIL = 3;
	localparam int MCSM_IRQ_HOLD     = 4;
	localparam int MCSM_IRQ_W        = 5;

	localparam logic [15:0] MCSM_CODE_NOP    = 16'h0000;
	localparam logic [15:0] MCSM_CODE_SVON   = 16'h001d;
	localparam logic [15:0] MCSM_CODE_SVOFF  = 16'h001e;
	localparam logic [15:0] MCSM_CODE_ALMCLR = 16'h001f;
	// Code of the absolute encoder reset command; value arbitrary
	localparam logic [15:0] MCSM_CODE_ABSRST = 16'h000d;

	localparam logic [15:0] MCSM_ZERO16 = 16'h0000;

	typedef enum logic [1:0] {
		MCSM_IDLE,
		MCSM_RUN,
		MCSM_ABORT
	} mcsm_state_type;

	// Execution engine result for one channel
	typedef struct packed {
		logic done;
		logic fail;
	} mcsm_result_type;

	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} mcsm_bus_type;

endpackage

/* File: design/mcsm_monitor.sv */
`timescale 1ns/1ps
module mcsm_monitor
	import mcsm_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire mcsm_bus_type bus,
	output logic [15:0]      rdata,
	input  wire mcsm_result_type cmd_res,
	input  wire mcsm_result_type sub_res,
	input  wire logic        hold_ack,
	output logic             cmd_start,
	output logic             sub_start,
	output logic [15:0]      cmd_exec_code,
	output logic [15:0]      sub_exec_code,
	output logic             axis_halt,
	output logic             irq
);

	function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
		return a == o;
	endfunction

	mcsm_state_type  cst_q, sst_q;
	logic [15:0]     cmd_req_q, sub_req_q, cmd_code_q, sub_code_q;
	logic            cmd_go_q, sub_go_q;
	logic            c_hold_q, c_fail_q, c_abs_q, c_done_q;
	logic            s_fail_q, s_done_q;
	logic            halt_q;
	logic [MCSM_IRQ_W-1:0] ist_q, imask_q, ev;
	logic [15:0]     rdata_q;

	wire wr_creq  = bus.wr && hit(bus.addr, MCSM_OFF_CMD_REQ);
	wire wr_sreq  = bus.wr && hit(bus.addr, MCSM_OFF_SUB_REQ);
	wire wr_ctl   = bus.wr && hit(bus.addr, MCSM_OFF_CTRL);
	wire wr_mask  = bus.wr && hit(bus.addr, MCSM_OFF_IRQ_MASK);
	wire rd_ist   = bus.rd && hit(bus.addr, MCSM_OFF_IRQ_STAT);
	wire req_hold = wr_ctl && bus.wdata[MCSM_CTL_HOLD];
	wire req_abrt = wr_ctl && bus.wdata[MCSM_CTL_ABORT];
	wire req_sabt = wr_ctl && bus.wdata[MCSM_CTL_SUBABRT];
	wire req_svon = wr_ctl && bus.wdata[MCSM_CTL_SVON];
	wire req_svof = wr_ctl && bus.wdata[MCSM_CTL_SVOFF];
	wire req_aclr = wr_ctl && bus.wdata[MCSM_CTL_ALMCLR];
	wire svc_load = req_svon || req_svof || req_aclr;
	wire [15:0] svc_code = req_svon ? MCSM_CODE_SVON :
		req_svof ? MCSM_CODE_SVOFF : MCSM_CODE_ALMCLR;
	wire cmd_idle = (cst_q == MCSM_IDLE);
	wire sub_idle = (sst_q == MCSM_IDLE);
	wire cmd_busy = !cmd_idle;
	wire sub_busy = !sub_idle;
	wire c_end    = (cst_q == MCSM_RUN) && (cmd_res.done || cmd_res.fail);
	wire s_end    = (sst_q == MCSM_RUN) && (sub_res.done || sub_res.fail);
	wire hold_end = c_hold_q == 1'b0 && cmd_busy && hold_ack;

	// Only documented bits are driven; the rest stay zero
	wire [15:0] cmd_stat = {7'h00, c_done_q, c_abs_q, 3'h0, c_fail_q,
		1'b0, c_hold_q, cmd_busy};
	wire [15:0] sub_stat = {7'h00, s_done_q, 4'h0, s_fail_q,
		2'h0, sub_busy};

	wire [15:0] rd_mux =
		hit(bus.addr, MCSM_OFF_CMD_CODE) ? cmd_code_q :
		hit(bus.addr, MCSM_OFF_CMD_STAT) ? cmd_stat :
		hit(bus.addr, MCSM_OFF_SUB_CODE) ? sub_code_q :
		hit(bus.addr, MCSM_OFF_SUB_STAT) ? sub_stat :
		hit(bus.addr, MCSM_OFF_CMD_REQ)  ? cmd_req_q :
		hit(bus.addr, MCSM_OFF_SUB_REQ)  ? sub_req_q :
		hit(bus.addr, MCSM_OFF_IRQ_STAT) ? {11'h000, ist_q} :
		hit(bus.addr, MCSM_OFF_IRQ_MASK) ? {11'h000, imask_q} :
		MCSM_ZERO16;

	assign ev[MCSM_IRQ_CMD_DONE] = c_end && !cmd_res.fail;
	assign ev[MCSM_IRQ_CMD_FAIL] = c_end && cmd_res.fail;
	assign ev[MCSM_IRQ_SUB_DONE] = s_end && !sub_res.fail;
	assign ev[MCSM_IRQ_SUB_FAIL] = s_end && sub_res.fail;
	assign ev[MCSM_IRQ_HOLD]     = hold_end;

	assign cmd_start     = cmd_go_q;
	assign sub_start     = sub_go_q;
	assign cmd_exec_code = cmd_code_q;
	assign sub_exec_code = sub_code_q;
	assign axis_halt     = halt_q;
	assign rdata         = rdata_q;
	assign irq           = |(ist_q & imask_q);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmd_req_q <= MCSM_ZERO16;
			sub_req_q <= MCSM_ZERO16;
			imask_q   <= '0;
			rdata_q   <= MCSM_ZERO16;
		end else begin
			if (wr_creq) begin
				cmd_req_q <= bus.wdata;
			end
			if (wr_sreq) begin
				sub_req_q <= bus.wdata;
			end
			if (wr_mask) begin
				imask_q <= bus.wdata[MCSM_IRQ_W-1:0];
			end
			rdata_q <= bus.rd ? rd_mux : MCSM_ZERO16;
		end
	end

	// Event set wins over the clear-on-read of the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ist_q <= '0;
		end else begin
			ist_q <= (rd_ist ? '0 : ist_q) | ev;
		end
	end

	// Main command channel; a new request is accepted only when idle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cst_q      <= MCSM_IDLE;
			cmd_code_q <= MCSM_CODE_NOP;
			cmd_go_q   <= 1'b0;
			c_hold_q   <= 1'b0;
			c_fail_q   <= 1'b0;
			c_abs_q    <= 1'b0;
			c_done_q   <= 1'b0;
			halt_q     <= 1'b0;
		end else begin
			cmd_go_q <= 1'b0;
			case (cst_q)
			MCSM_IDLE: begin
				if (svc_load) begin
					cmd_code_q <= svc_code;
					halt_q     <= 1'b0;
				end else if (wr_creq) begin
					cmd_code_q <= bus.wdata;
					c_fail_q   <= 1'b0;
					c_done_q   <= 1'b0;
					c_hold_q   <= 1'b0;
					c_abs_q    <= 1'b0;
					halt_q     <= 1'b0;
					cmd_go_q   <= 1'b1;
					cst_q      <= MCSM_RUN;
				end
			end
			MCSM_RUN: begin
				if (hold_end && req_hold == 1'b0) begin
					c_hold_q <= 1'b1;
				end
				if (req_abrt) begin
					cst_q <= MCSM_ABORT;
				end else if (c_end) begin
					cst_q <= MCSM_IDLE;
					if (cmd_res.fail) begin
						c_fail_q <= 1'b1;
						halt_q   <= 1'b1;
					end else begin
						c_done_q <= 1'b1;
						c_abs_q  <= (cmd_code_q == MCSM_CODE_ABSRST);
					end
				end
			end
			MCSM_ABORT: begin
				halt_q <= 1'b1;
				if (cmd_res.done || cmd_res.fail) begin
					cst_q <= MCSM_IDLE;
				end
			end
			default: cst_q <= MCSM_IDLE;
			endcase
		end
	end

	// Subcommand channel runs beside the main one with no coupling
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sst_q      <= MCSM_IDLE;
			sub_code_q <= MCSM_CODE_NOP;
			sub_go_q   <= 1'b0;
			s_fail_q   <= 1'b0;
			s_done_q   <= 1'b0;
		end else begin
			sub_go_q <= 1'b0;
			case (sst_q)
			MCSM_IDLE: begin
				if (wr_sreq) begin
					sub_code_q <= bus.wdata;
					s_fail_q   <= 1'b0;
					s_done_q   <= 1'b0;
					sub_go_q   <= 1'b1;
					sst_q      <= MCSM_RUN;
				end
			end
			MCSM_RUN: begin
				if (req_sabt) begin
					sst_q <= MCSM_ABORT;
				end else if (s_end) begin
					sst_q <= MCSM_IDLE;
					if (sub_res.fail) begin
						s_fail_q <= 1'b1;
					end else begin
						s_done_q <= 1'b1;
					end
				end
			end
			MCSM_ABORT: begin
				if (sub_res.done || sub_res.fail) begin
					sst_q <= MCSM_IDLE;
				end
			end
			default: sst_q <= MCSM_IDLE;
			endcase
		end
	end

endmodule // mcsm_monitor

/* File: bench/mcsm_chk.sv */
`timescale 1ns/1ps
module mcsm_chk
	import mcsm_pkg::*;
(
	input wire logic            clk,
	input wire logic            rst,
	input wire mcsm_bus_type    bus,
	input wire logic [15:0]     rdata,
	input wire mcsm_result_type cmd_res,
	input wire logic            cmd_start,
	input wire logic            sub_start,
	input wire logic [15:0]     cmd_exec_code,
	input wire logic [15:0]     sub_exec_code,
	input wire logic            axis_halt
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence rd_at(logic [3:0] a);
		bus.rd && bus.addr == a;
	endsequence
	sequence run_fail;
		cmd_start ##[1:20] cmd_res.fail;
	endsequence
	cmd_read_a: assert property (
		rd_at(MCSM_OFF_CMD_CODE) |=> rdata == $past(cmd_exec_code))
		else $error("command code read wrong");
	sub_read_a: assert property (
		rd_at(MCSM_OFF_SUB_CODE) |=> rdata == $past(sub_exec_code))
		else $error("subcommand code read wrong");
	cmd_rsvd_a: assert property (
		rd_at(MCSM_OFF_CMD_STAT) |=> (rdata & 16'hfe74) == 16'h0000)
		else $error("command status spare bit set");
	sub_rsvd_a: assert property (
		rd_at(MCSM_OFF_SUB_STAT) |=> (rdata & 16'hfef6) == 16'h0000)
		else $error("subcommand status spare bit set");
	cmd_keep_a: assert property (
		!cmd_start && !$past(bus.wr && bus.addr == MCSM_OFF_CTRL)
		|-> $stable(cmd_exec_code)) else $error("command code moved");
	cmd_take_a: assert property (
		cmd_start |-> $past(bus.wr) && $past(bus.addr) == MCSM_OFF_CMD_REQ
		&& cmd_exec_code == $past(bus.wdata)) else $error("bad accept");
	sub_take_a: assert property (
		sub_start |-> $past(bus.wr) && $past(bus.addr) == MCSM_OFF_SUB_REQ
		&& sub_exec_code == $past(bus.wdata)) else $error("bad sub accept");
	halt_fail_a: assert property (
		run_fail |=> axis_halt) else $error("no halt after error");
endmodule // mcsm_chk
bind mcsm_monitor mcsm_chk mcsm_chk_inst (.clk(clk), .rst(rst), .bus(bus),
	.rdata(rdata), .cmd_res(cmd_res), .cmd_start(cmd_start),
	.sub_start(sub_start), .cmd_exec_code(cmd_exec_code),
	.sub_exec_code(sub_exec_code), .axis_halt(axis_halt));

/* File: bench/mcsm_engine.sv */
`timescale 1ns/1ps
module mcsm_engine
	import mcsm_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       start,
	input  wire logic [3:0] lat,
	input  wire logic       bad,
	output mcsm_result_type res
);
	logic [3:0] cnt_q;
	logic       run_q;
	// Answers lat+2 cycles after start with a one-cycle result
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 4'h0;
			run_q <= 1'b0;
			res   <= '0;
		end else begin
			res <= '0;
			if (start) begin
				run_q <= 1'b1;
				cnt_q <= lat;
			end else if (run_q && cnt_q == 4'h0) begin
				run_q <= 1'b0;
				res   <= '{!bad, bad};
			end else begin
				cnt_q <= cnt_q - 4'h1;
			end
		end
	end
endmodule // mcsm_engine

/* File: bench/mcsm_monitor_tb_top.sv */
`timescale 1ns/1ps
module mcsm_monitor_tb_top import mcsm_pkg::*;;
	logic            clk = 1'b0;
	logic            rst = 1'b1;
	logic            hold_ack = 1'b0;
	logic            bad = 1'b0;
	logic [3:0]      lat = 4'hf;
	mcsm_bus_type    bus = '0;
	mcsm_result_type cmd_res;
	mcsm_result_type sub_res;
	logic [15:0]     rdata;
	logic [15:0]     cmd_code;
	logic [15:0]     sub_code;
	logic            cmd_start;
	logic            sub_start;
	logic            axis_halt;
	logic            irq;
	int              n_errors = 0;
	int              comparisons = 0;
	mcsm_monitor mcsm_monitor_inst (.clk(clk), .rst(rst), .bus(bus),
		.rdata(rdata), .cmd_res(cmd_res), .sub_res(sub_res),
		.hold_ack(hold_ack), .cmd_start(cmd_start), .sub_start(sub_start),
		.cmd_exec_code(cmd_code), .sub_exec_code(sub_code),
		.axis_halt(axis_halt), .irq(irq));
	mcsm_engine mcsm_engine_cmd (.clk(clk), .rst(rst), .start(cmd_start),
		.lat(lat), .bad(bad), .res(cmd_res));
	mcsm_engine mcsm_engine_sub (.clk(clk), .rst(rst), .start(sub_start),
		.lat(lat), .bad(bad), .res(sub_res));
	initial forever #50 clk = ~clk;
	task automatic ck(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		bus <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 ck(rdata, e);
	endtask
	task automatic run(input logic [3:0] a, input logic [15:0] c,
		input logic b, input logic [3:0] sa, input logic [15:0] e);
		bad <= b;
		wr(a, c);
		repeat (12) @(posedge clk);
		rd(sa, e);
	endtask
	task automatic stop_test;
		if (n_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#300000;
		n_errors++;
		stop_test;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(MCSM_OFF_CMD_STAT, 16'h0000);
		rd(4'h5, 16'h0000);
		wr(MCSM_OFF_IRQ_MASK, 16'h001f);
		wr(MCSM_OFF_CMD_REQ, 16'hffff);
		rd(MCSM_OFF_CMD_STAT, 16'h0001);
		wr(MCSM_OFF_CMD_REQ, 16'h5555);
		rd(MCSM_OFF_CMD_CODE, 16'hffff);
		wr(MCSM_OFF_CTRL, 16'h0001);
		hold_ack <= 1'b1;
		@(posedge clk) hold_ack <= 1'b0;
		rd(MCSM_OFF_CMD_STAT, 16'h0003);
		repeat (16) @(posedge clk);
		rd(MCSM_OFF_CMD_STAT, 16'h0102);
		ck({15'h0000, irq}, 16'h0001);
		rd(MCSM_OFF_IRQ_STAT, 16'h0011);
		ck({15'h0000, irq}, 16'h0000);
		wr(MCSM_OFF_CMD_REQ, 16'h0021);
		wr(MCSM_OFF_CTRL, 16'h0002);
		rd(MCSM_OFF_CMD_STAT, 16'h0001);
		repeat (20) @(posedge clk);
		rd(MCSM_OFF_CMD_STAT, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			wr(MCSM_OFF_CTRL, 16'h0008 << i);
			rd(MCSM_OFF_CMD_CODE, MCSM_CODE_SVON + 16'(i));
		end
		ck({15'h0000, axis_halt}, 16'h0000);
		lat <= 4'h3;
		run(MCSM_OFF_CMD_REQ, 16'h0042, 1'b1, MCSM_OFF_CMD_STAT, 16'h0008);
		ck({15'h0000, axis_halt}, 16'h0001);
		run(MCSM_OFF_CMD_REQ, MCSM_CODE_ABSRST, 1'b0, MCSM_OFF_CMD_STAT,
			16'h0180);
		wr(MCSM_OFF_SUB_REQ, 16'h0077);
		rd(MCSM_OFF_SUB_STAT, 16'h0001);
		wr(MCSM_OFF_CMD_REQ, 16'h0009);
		rd(MCSM_OFF_SUB_CODE, 16'h0077);
		rd(MCSM_OFF_CMD_CODE, 16'h0009);
		repeat (12) @(posedge clk);
		rd(MCSM_OFF_SUB_STAT, 16'h0100);
		run(MCSM_OFF_SUB_REQ, 16'h0078, 1'b1, MCSM_OFF_SUB_STAT, 16'h0008);
		wr(MCSM_OFF_SUB_REQ, 16'h0079);
		wr(MCSM_OFF_CTRL, 16'h0004);
		rd(MCSM_OFF_SUB_STAT, 16'h0001);
		repeat (8) @(posedge clk);
		rd(MCSM_OFF_SUB_STAT, 16'h0000);
		stop_test;
	end
endmodule // mcsm_monitor_tb_top
